// ==== inc/csp_pkg.sv ====
// Shared constants and types of the stack pointer unit.
// Assumes a single core clock and an asynchronous active-high reset.
`default_nettype none

package csp_pkg;

    // ------------------------------------------------------------
    // Pointer layout
    // ------------------------------------------------------------
    localparam int          OFS_W       = 6;
    localparam logic [9:0]  SP_FIXED_HI = 10'h003;   // Bits 15:8 zero, 7:6 one
    localparam logic [5:0]  OFS_RESET   = 6'h3F;     // Top of the stack
    localparam logic [15:0] SP_RESET    = 16'h00FF;
    localparam logic [5:0]  OFS_ONE     = 6'h01;
    localparam logic [5:0]  OFS_TWO     = 6'h02;
    localparam logic [5:0]  OFS_FIVE    = 6'h05;

    // ------------------------------------------------------------
    // Context layout and sequence lengths
    // ------------------------------------------------------------
    localparam int         CTX_W    = 40;  // {cc, a, x, pc_hi, pc_lo}
    localparam int         BYTE_W   = 8;
    localparam logic [2:0] LEN_ONE  = 3'h1;
    localparam logic [2:0] LEN_CALL = 3'h2;
    localparam logic [2:0] LEN_INT  = 3'h5;

    // Operations issued by the instruction sequencer
    typedef enum logic [2:0] {
        CSP_OP_PUSH = 3'h0,
        CSP_OP_POP  = 3'h1,
        CSP_OP_CALL = 3'h2,
        CSP_OP_RET  = 3'h3,
        CSP_OP_INT  = 3'h4,
        CSP_OP_IRET = 3'h5,
        CSP_OP_RSP  = 3'h6,
        CSP_OP_LDSP = 3'h7
    } csp_op_e;

    // Commands to the pointer register
    typedef enum logic [2:0] {
        CSP_PTR_HOLD  = 3'h0,
        CSP_PTR_DEC   = 3'h1,
        CSP_PTR_INC   = 3'h2,
        CSP_PTR_LOAD  = 3'h3,
        CSP_PTR_RESET = 3'h4
    } csp_ptr_cmd_e;

    // Sequencer states, Gray along idle, read, capture
    typedef enum logic [1:0] {
        CSP_ST_IDLE    = 2'h0,
        CSP_ST_POP_RD  = 2'h1,
        CSP_ST_POP_CAP = 2'h3,
        CSP_ST_PUSH    = 2'h2
    } csp_state_e;

    typedef struct packed {
        csp_state_e         state;
        logic [2:0]         count;
        logic [CTX_W-1:0]   shreg;
        logic [CTX_W-1:0]   result;
        logic               done;
    } csp_main_s;

    typedef struct packed {
        logic [OFS_W-1:0]   ofs;
    } csp_ptr_s;

endpackage : csp_pkg

`default_nettype wire

// ==== inc/csp_ptr_if.sv ====
// Carrier between the stack sequencer and the pointer register.
// Assumes both ends sit in the same clock domain.
`default_nettype none

interface csp_ptr_if;
    import csp_pkg::*;

    csp_ptr_cmd_e       cmd;       // Pointer update request
    logic [OFS_W-1:0]   load_val;  // Low bits for a direct load
    logic [15:0]        value;     // Current full pointer
    logic [15:0]        above;     // Pointer plus one, wrapped

    modport ctrl (output cmd, output load_val, input value, input above);
    modport ptr  (input cmd, input load_val, output value, output above);
endinterface : csp_ptr_if

`default_nettype wire

// ==== verilog/csp_pointer.sv ====
// Stack pointer register with hardware-forced upper bits.
// Assumes the sequencer issues one command per clock.
`default_nettype none

module csp_pointer (
    input  wire logic clk_i,
    input  wire logic reset_i,
    csp_ptr_if.ptr    pif
);
    import csp_pkg::*;

    csp_ptr_s r_reg;
    csp_ptr_s r_next;

    // ------------------------------------------------------------
    // Pointer update
    // ------------------------------------------------------------
    // Six-bit arithmetic wraps inside the region by itself
    always_comb begin
        r_next = r_reg;
        case (pif.cmd)
            CSP_PTR_DEC:   r_next.ofs = r_reg.ofs - OFS_ONE;
            CSP_PTR_INC:   r_next.ofs = r_reg.ofs + OFS_ONE;
            CSP_PTR_LOAD:  r_next.ofs = pif.load_val;
            CSP_PTR_RESET: r_next.ofs = OFS_RESET;
            default:       r_next.ofs = r_reg.ofs;
        endcase
    end

    // Register; reset lands on the top of the stack
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            r_reg.ofs <= OFS_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // Upper ten bits never leave their fixed value
    assign pif.value = {SP_FIXED_HI, r_reg.ofs};
    assign pif.above = {SP_FIXED_HI, r_reg.ofs + OFS_ONE};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_fixed_upper_bits: assert property (pif.value[15:6] == SP_FIXED_HI)
        else $error("pointer upper bits not forced");
    a_reset_cmd_value: assert property (pif.cmd == CSP_PTR_RESET |=> pif.value == SP_RESET)
        else $error("reset command did not restore pointer");
    a_load_low_bits: assert property (pif.cmd == CSP_PTR_LOAD
        |=> pif.value[5:0] == $past(pif.load_val))
        else $error("direct load not taken");
    a_dec_wraps_top: assert property (pif.cmd == CSP_PTR_DEC && pif.value[5:0] == 6'h00
        |=> pif.value == SP_RESET)
        else $error("push below bottom did not wrap");

endmodule : csp_pointer

`default_nettype wire

// ==== verilog/csp_stack_unit.sv ====
// Stack pointer unit of an 8-bit core: sequences pushes and pops.
// Assumes a synchronous stack RAM that returns read data one clock
// after the read strobe, and a sequencer that waits on ready.
//
// What this block does
// - Keep 16-bit pointer at next free location
// - Decrement pointer after each byte pushed
// - Increment pointer before each byte popped
// - Sixty-four bytes; upper ten bits forced
// - Reset and reset instruction load top address
// - Low pointer byte readable; its low six bits loadable directly
// - Push below bottom wraps silently to top
// - Pop above top wraps silently to bottom
// - Call saves two bytes, interrupt five
// - Interrupt stores low PC byte first
// - Interrupt return pops context with increments
// - Single-byte push and pop share same rules
`default_nettype none

module csp_stack_unit (
    input  wire logic                   clk_i,
    input  wire logic                   reset_i,
    input  wire logic                   op_valid_i,
    input  wire csp_pkg::csp_op_e       op_i,
    input  wire logic [csp_pkg::CTX_W-1:0] ctx_i,
    output logic                        ready_o,
    output logic                        done_o,
    output logic [csp_pkg::CTX_W-1:0]   result_o,
    output logic [15:0]                 sp_o,
    output logic [15:0]                 mem_addr_o,
    output logic [7:0]                  mem_wdata_o,
    output logic                        mem_we_o,
    output logic                        mem_re_o,
    input  wire logic [7:0]             mem_rdata_i
);
    import csp_pkg::*;

    csp_main_s  r_reg;
    csp_main_s  r_next;
    csp_ptr_if  pif ();
    logic       accept;

    // ------------------------------------------------------------
    // Pointer register
    // ------------------------------------------------------------
    csp_pointer u_pointer (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pif     (pif)
    );

    assign accept = op_valid_i && (r_reg.state == CSP_ST_IDLE);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // One byte moves per push cycle; a pop byte takes a read
    // cycle and a capture cycle, which keeps the RAM path simple
    // at the cost of half the pop bandwidth.
    always_comb begin
        r_next       = r_reg;
        r_next.done  = 1'b0;
        pif.cmd      = CSP_PTR_HOLD;
        pif.load_val = ctx_i[OFS_W-1:0];
        case (r_reg.state)
            CSP_ST_IDLE: begin
                if (op_valid_i) begin
                    case (op_i)
                        CSP_OP_PUSH: begin
                            r_next.shreg = {32'h0000_0000, ctx_i[7:0]};
                            r_next.count = LEN_ONE;
                            r_next.state = CSP_ST_PUSH;
                        end
                        CSP_OP_CALL: begin
                            r_next.shreg = {24'h00_0000, ctx_i[15:0]};
                            r_next.count = LEN_CALL;
                            r_next.state = CSP_ST_PUSH;
                        end
                        CSP_OP_INT: begin
                            r_next.shreg = ctx_i;
                            r_next.count = LEN_INT;
                            r_next.state = CSP_ST_PUSH;
                        end
                        CSP_OP_POP: begin
                            r_next.shreg = '0;
                            r_next.count = LEN_ONE;
                            r_next.state = CSP_ST_POP_RD;
                        end
                        CSP_OP_RET: begin
                            r_next.shreg = '0;
                            r_next.count = LEN_CALL;
                            r_next.state = CSP_ST_POP_RD;
                        end
                        CSP_OP_IRET: begin
                            r_next.shreg = '0;
                            r_next.count = LEN_INT;
                            r_next.state = CSP_ST_POP_RD;
                        end
                        CSP_OP_RSP: begin
                            pif.cmd     = CSP_PTR_RESET;
                            r_next.done = 1'b1;
                        end
                        CSP_OP_LDSP: begin
                            pif.cmd     = CSP_PTR_LOAD;
                            r_next.done = 1'b1;
                        end
                        default: begin
                            r_next.done = 1'b1;
                        end
                    endcase
                end
            end
            CSP_ST_PUSH: begin
                // Byte is written at the pointer, then it moves down
                pif.cmd      = CSP_PTR_DEC;
                r_next.shreg = r_reg.shreg >> BYTE_W;
                r_next.count = r_reg.count - 3'h1;
                if (r_reg.count == LEN_ONE) begin
                    r_next.state = CSP_ST_IDLE;
                    r_next.done  = 1'b1;
                end
            end
            CSP_ST_POP_RD: begin
                // Pointer moves up before the byte is read
                pif.cmd      = CSP_PTR_INC;
                r_next.state = CSP_ST_POP_CAP;
            end
            CSP_ST_POP_CAP: begin
                // Bytes shift in at the bottom, so the last one
                // popped lands in the low byte: reverse of pushing
                r_next.shreg = {r_reg.shreg[CTX_W-9:0], mem_rdata_i};
                r_next.count = r_reg.count - 3'h1;
                if (r_reg.count == LEN_ONE) begin
                    r_next.state  = CSP_ST_IDLE;
                    r_next.result = {r_reg.shreg[CTX_W-9:0], mem_rdata_i};
                    r_next.done   = 1'b1;
                end else begin
                    r_next.state = CSP_ST_POP_RD;
                end
            end
            default: begin
                r_next.state = CSP_ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            r_reg.state  <= CSP_ST_IDLE;
            r_reg.count  <= 3'h0;
            r_reg.shreg  <= '0;
            r_reg.result <= '0;
            r_reg.done   <= 1'b0;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Ready and strobes decode the state; done and data come from flip-flops
    assign ready_o     = (r_reg.state == CSP_ST_IDLE);
    assign done_o      = r_reg.done;
    assign result_o    = r_reg.result;
    assign sp_o        = pif.value;
    assign mem_we_o    = (r_reg.state == CSP_ST_PUSH);
    assign mem_re_o    = (r_reg.state == CSP_ST_POP_RD);
    assign mem_wdata_o = r_reg.shreg[7:0];
    // Pop reads one above, since the pointer names a free slot
    assign mem_addr_o  = mem_re_o ? pif.above : pif.value;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_push_moves_down: assert property (mem_we_o
        |=> sp_o[5:0] == $past(mem_addr_o[5:0]) - 6'h01)
        else $error("pointer did not drop after a write");
    a_pop_reads_above: assert property (mem_re_o
        |=> sp_o == $past(mem_addr_o))
        else $error("pop read was not at the raised pointer");
    a_int_five_writes: assert property (accept && op_i == CSP_OP_INT
        |=> mem_we_o [*5] ##1 !mem_we_o ##0 done_o)
        else $error("interrupt entry did not store five bytes");
    a_call_two_writes: assert property (accept && op_i == CSP_OP_CALL
        |=> mem_we_o [*2] ##1 !mem_we_o)
        else $error("call did not store two bytes");
    a_int_pcl_first: assert property (accept && op_i == CSP_OP_INT
        |=> mem_wdata_o == $past(ctx_i[7:0]) && mem_addr_o == $past(sp_o))
        else $error("interrupt entry did not start with PC low");
    a_int_cc_last: assert property (accept && op_i == CSP_OP_INT
        |=> ##4 mem_wdata_o == $past(ctx_i[39:32], 5))
        else $error("condition codes not stored last");
    a_call_high_second: assert property (accept && op_i == CSP_OP_CALL
        |=> ##1 mem_wdata_o == $past(ctx_i[15:8], 2))
        else $error("call did not store high byte second");
    a_iret_done_time: assert property (accept && op_i == CSP_OP_IRET
        |-> ##11 done_o && sp_o[5:0] == $past(sp_o[5:0], 11) + OFS_FIVE)
        else $error("interrupt return did not pop five bytes");
    a_ret_restores_sp: assert property (accept && op_i == CSP_OP_RET
        |-> ##5 done_o && sp_o[5:0] == $past(sp_o[5:0], 5) + OFS_TWO)
        else $error("return did not raise pointer by two");
    a_pop_single_byte: assert property (accept && op_i == CSP_OP_POP
        |-> ##3 done_o && result_o[7:0] == $past(mem_rdata_i))
        else $error("single pop did not return its byte");
    a_rsp_top_value: assert property (accept && op_i == CSP_OP_RSP
        |=> sp_o == SP_RESET && done_o)
        else $error("reset instruction did not restore pointer");

    c_int_entry: cover property (accept && op_i == CSP_OP_INT ##6 done_o);
    c_iret_full: cover property (accept && op_i == CSP_OP_IRET ##11 done_o);
    c_push_wrap: cover property (mem_we_o && sp_o[5:0] == 6'h00);
    c_pop_wrap: cover property (mem_re_o && sp_o[5:0] == 6'h3F);

endmodule : csp_stack_unit

`default_nettype wire

// ==== bench/csp_ram_model.sv ====
// Behavioural stack RAM on the far side of the stack pointer unit.
// Assumes byte strobes on the core clock and a fixed one-cycle read latency.
`default_nettype none

module csp_ram_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        we_i,
    input  wire logic        re_i,
    output logic      [7:0]  rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Storage and address watch
    // ------------------------------------------------------------
    logic [7:0] mem [64];
    int         bad_addr;

    initial begin
        bad_addr = 0;
        rdata_o  = 8'h00;
    end

    // Read data is valid only in the cycle after the strobe; otherwise the
    // bus toggles so that a late or early capture cannot pass by chance
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i[5:0]] <= wdata_i;
        end
        if (re_i) begin
            rdata_o <= mem[addr_i[5:0]];
        end else begin
            rdata_o <= ~rdata_o;
        end
        if ((we_i || re_i) && addr_i[15:6] !== 10'h003) begin
            bad_addr <= bad_addr + 1;
        end
    end
endmodule : csp_ram_model

`default_nettype wire

// ==== bench/cpu_stack_pointer_test.sv ====
// Self-checking bench of the stack pointer unit with its RAM partner.
// Assumes the package, design sources and RAM model are compiled first.
`default_nettype none

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("[ERR] t=%0t got %h exp %h", $time, got, exp); end end

module cpu_stack_pointer_test;
    import csp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i;
    logic        reset_i;
    logic        op_valid_i;
    csp_op_e     op_i;
    logic [39:0] ctx_i;
    logic        ready_o;
    logic        done_o;
    logic [39:0] result_o;
    logic [15:0] sp_o;
    logic [15:0] mem_addr_o;
    logic [7:0]  mem_wdata_o;
    logic        mem_we_o;
    logic        mem_re_o;
    logic [7:0]  mem_rdata_i;
    int          mismatches;
    int          n_checks;

    // ------------------------------------------------------------
    // Design and partner
    // ------------------------------------------------------------
    csp_stack_unit csp_stack_unit_inst (
        .clk_i(clk_i), .reset_i(reset_i), .op_valid_i(op_valid_i), .op_i(op_i),
        .ctx_i(ctx_i), .ready_o(ready_o), .done_o(done_o), .result_o(result_o),
        .sp_o(sp_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
        .mem_we_o(mem_we_o), .mem_re_o(mem_re_o), .mem_rdata_i(mem_rdata_i)
    );

    csp_ram_model csp_ram_model_inst (
        .clk_i(clk_i), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
        .we_i(mem_we_o), .re_i(mem_re_o), .rdata_o(mem_rdata_i)
    );

    // Core clock, 100 MHz
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    // One operation: request held until the accepting edge, then the done
    // pulse is awaited under a bound and its cycle number compared; the
    // count starts at one just after the accepting edge, because a one-cycle
    // operation raises done_o right there and a later first look misses it
    task automatic do_op(input csp_op_e op, input logic [39:0] ctx, input int lat);
        int n;
        n = 0;
        @(posedge clk_i);
        op_valid_i <= 1'b1;
        op_i       <= op;
        ctx_i      <= ctx;
        @(posedge clk_i);
        op_valid_i <= 1'b0;
        n = 1;
        #1;
        while (done_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n >= 20) begin
            mismatches++;
            print_verdict();
        end else begin
            `CHK(n, lat)
        end
    endtask : do_op

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        #1;
        `CHK(sp_o, 16'h00FF)
        `CHK(ready_o, 1'b1)
        $display("test reset done");
    endtask : test_reset

    task automatic test_push_pop();
        do_op(CSP_OP_PUSH, 40'h00000000A5, 2);
        `CHK(sp_o, 16'h00FE)
        `CHK(csp_ram_model_inst.mem[6'h3F], 8'hA5)
        do_op(CSP_OP_POP, 40'h0, 3);
        `CHK(sp_o, 16'h00FF)
        `CHK(result_o, 40'h00000000A5)
        $display("test push_pop done");
    endtask : test_push_pop

    task automatic test_call_ret();
        do_op(CSP_OP_CALL, 40'h0000001234, 3);
        `CHK(sp_o, 16'h00FD)
        `CHK(csp_ram_model_inst.mem[6'h3F], 8'h34)
        `CHK(csp_ram_model_inst.mem[6'h3E], 8'h12)
        do_op(CSP_OP_RET, 40'h0, 5);
        `CHK(result_o, 40'h0000001234)
        `CHK(sp_o, 16'h00FF)
        $display("test call_ret done");
    endtask : test_call_ret

    task automatic test_int();
        logic [39:0] ctx;
        ctx = 40'hCCAA551234;
        do_op(CSP_OP_INT, ctx, 6);
        `CHK(sp_o, 16'h00FA)
        // Context lands at falling addresses, program counter low first
        for (int i = 0; i < 5; i++) begin
            `CHK(csp_ram_model_inst.mem[6'h3F - 6'(i)], ctx[8*i +: 8])
        end
        do_op(CSP_OP_IRET, 40'h0, 11);
        `CHK(result_o, ctx)
        `CHK(sp_o, 16'h00FF)
        $display("test int done");
    endtask : test_int

    task automatic test_wrap();
        do_op(CSP_OP_LDSP, 40'h000000002B, 1);
        `CHK(sp_o, 16'h00EB)
        do_op(CSP_OP_LDSP, 40'h0000000000, 1);
        `CHK(sp_o, 16'h00C0)
        do_op(CSP_OP_PUSH, 40'h000000005A, 2);
        `CHK(sp_o, 16'h00FF)
        `CHK(csp_ram_model_inst.mem[6'h00], 8'h5A)
        do_op(CSP_OP_POP, 40'h0, 3);
        `CHK(result_o, 40'h000000005A)
        `CHK(sp_o, 16'h00C0)
        do_op(CSP_OP_RSP, 40'h0, 1);
        `CHK(sp_o, 16'h00FF)
        `CHK(csp_ram_model_inst.bad_addr, 0)
        $display("test wrap done");
    endtask : test_wrap

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        mismatches = 0;
        n_checks   = 0;
        reset_i    = 1'b1;
        op_valid_i = 1'b0;
        op_i       = CSP_OP_PUSH;
        ctx_i      = 40'h0;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        test_reset();
        test_push_pop();
        test_call_ret();
        test_int();
        test_wrap();
        print_verdict();
    end
endmodule : cpu_stack_pointer_test

`undef CHK
`default_nettype wire
